/* logic/sdwit_bank_mem.v */
`timescale 1ns/1ps
`default_nettype none
// Flip-flop storage with byte-lane write masks
module sdwit_bank_mem #(
    parameter AW = 5,
    parameter DW = 16
) (
    // Clock
    input  wire          clock,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [1:0]    wr_mask,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    // Storage array, not reset: contents are undefined at power-up
    reg [DW-1:0] mem_reg [0:(1<<AW)-1];

    // Masked lanes keep their old contents
    always @(posedge clock) begin
        if (wr_en) begin
            if (!wr_mask[0]) begin
                mem_reg[wr_addr][DW/2-1:0] <= wr_data[DW/2-1:0];
            end
            if (!wr_mask[1]) begin
                mem_reg[wr_addr][DW-1:DW/2] <= wr_data[DW-1:DW/2];
            end
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule // sdwit_bank_mem
`default_nettype wire

/* logic/sdwit_core.v */
// Contract
// - Read ends write; keep previous word only
// - New write supersedes burst same edge
// - Deactivate ends write burst immediately
// - Stop drops current word, bank stays
// - First write word on command edge
// - Read data after programmed latency
`timescale 1ns/1ps
`default_nettype none
`include "sdwit_map.vh"
module sdwit_core #(
    parameter AW = 4,
    parameter DW = 16
) (
    // Clock and reset
    input  wire          clock,
    input  wire          rst,
    // Command port from controller pins
    input  wire          cs_n,
    input  wire          ras_n,
    input  wire          cas_n,
    input  wire          we_n,
    input  wire [11:0]   addr,
    input  wire [1:0]    dqm,
    // Data bus, three signals
    input  wire [DW-1:0] dq_in,
    output reg  [DW-1:0] dq_out,
    output reg           dq_oe_n,
    // State visible to the system
    output reg  [1:0]    bank_active,
    output reg           write_burst
);
    // Synchronised pin samples; whole command delayed two cycles together
    reg [17+DW:0] pin_s1_reg;
    reg [17+DW:0] pin_s2_reg;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_reg <= {(18+DW){1'b1}};
            pin_s2_reg <= {(18+DW){1'b1}};
        end else begin
            pin_s1_reg <= {cs_n, ras_n, cas_n, we_n, addr, dqm, dq_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    wire          s_cs_n = pin_s2_reg[17+DW];
    wire [2:0]    s_cmd  = pin_s2_reg[16+DW:14+DW];
    wire [11:0]   s_addr = pin_s2_reg[13+DW:2+DW];
    wire [1:0]    s_dqm  = pin_s2_reg[1+DW:DW];
    wire [DW-1:0] s_dq   = pin_s2_reg[DW-1:0];
    wire [2:0]    cmd    = s_cs_n ? `SDWIT_CMD_NOP : s_cmd;
    wire          s_bank = s_addr[`SDWIT_BANK_BIT];

    // Burst length from the mode field
    function [3:0] bl_words;
        input [2:0] code;
        begin
            case (code)
                3'h0: bl_words = 4'h1;
                3'h1: bl_words = 4'h2;
                3'h2: bl_words = 4'h4;
                default: bl_words = 4'h8;
            endcase
        end
    endfunction

    // Column step: serial adds, interleave xors, within the burst window
    function [2:0] next_col;
        input [2:0] start;
        input [2:0] idx;
        input       ilv;
        input [3:0] len;
        reg   [2:0] wrap;
        begin
            wrap = len[2:0] - 3'h1;
            if (len == 4'h8) wrap = 3'h7;
            if (ilv) next_col = (start & ~wrap) | ((start ^ idx) & wrap);
            else next_col = (start & ~wrap) | ((start + idx) & wrap);
        end
    endfunction

    // Mode register contents
    reg [1:0] rl_reg;
    reg [2:0] bl_reg;
    reg       ilv_reg;
    reg       wb1_reg;
    // Write burst tracking
    reg [3:0] wr_left_reg;
    reg [2:0] wr_start_reg;
    reg [2:0] wr_idx_reg;
    reg       wr_bank_reg;
    reg       wr_ap_reg;
    // Read burst tracking
    reg [3:0] rd_left_reg;
    reg [2:0] rd_start_reg;
    reg [2:0] rd_idx_reg;
    reg       rd_bank_reg;
    // Read data valid pipeline, one stage per latency cycle
    reg [2:0] rd_pipe_reg;
    // Read data delay taps, kept in step with the valid pipeline
    reg [DW-1:0] rd_dly1_reg;
    reg [DW-1:0] rd_dly2_reg;

    // Write and read ports into storage
    reg          mem_we;
    reg [AW-1:0] mem_waddr;
    reg [AW-1:0] mem_raddr;
    wire [DW-1:0] mem_rdata;

    wire [3:0] burst_len = bl_words(bl_reg);
    wire [3:0] wlen      = wb1_reg ? 4'h1 : burst_len;
    wire       new_write = (cmd == `SDWIT_CMD_WRITE);
    wire       new_read  = (cmd == `SDWIT_CMD_READ);
    wire       rd_go     = rd_left_reg != 4'h0;

    // Storage write decode: new command word or continuing burst word
    always @* begin
        mem_we    = 1'b0;
        mem_waddr = {AW{1'b0}};
        mem_raddr = {AW{1'b0}};
        if (new_write && bank_active[s_bank]) begin
            mem_we          = 1'b1;
            mem_waddr[AW-1] = s_bank;
            mem_waddr[2:0]  = s_addr[2:0];
        end else if (write_burst && cmd == `SDWIT_CMD_NOP) begin
            mem_we          = 1'b1;
            mem_waddr[AW-1] = wr_bank_reg;
            mem_waddr[2:0]  =
                next_col(wr_start_reg, wr_idx_reg, ilv_reg, wlen);
        end
        // other commands write nothing this edge
        // Bank bit on top, column low; set bit by bit so any AW of 4 or more fits
        mem_raddr[AW-1] = rd_bank_reg;
        mem_raddr[2:0]  =
            next_col(rd_start_reg, rd_idx_reg, ilv_reg, burst_len);
    end

    sdwit_bank_mem #(.AW(AW), .DW(DW)) u_mem (
        .clock   (clock),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (s_dq),
        .wr_mask (s_dqm),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // Command sequencing and burst bookkeeping
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rl_reg       <= `SDWIT_RL_RESET;
            bl_reg       <= `SDWIT_BL_RESET;
            ilv_reg      <= 1'b0;
            wb1_reg      <= 1'b0;
            bank_active  <= 2'h0;
            write_burst  <= 1'b0;
            wr_left_reg  <= 4'h0;
            wr_start_reg <= 3'h0;
            wr_idx_reg   <= 3'h0;
            wr_bank_reg  <= 1'b0;
            wr_ap_reg    <= 1'b0;
            rd_left_reg  <= 4'h0;
            rd_start_reg <= 3'h0;
            rd_idx_reg   <= 3'h0;
            rd_bank_reg  <= 1'b0;
        end else begin
            // Burst word counters advance every edge while their burst runs
            if (write_burst) begin
                wr_idx_reg  <= wr_idx_reg + 3'h1;
                wr_left_reg <= wr_left_reg - 4'h1;
                if (wr_left_reg == 4'h1) begin
                    write_burst <= 1'b0;
                    if (wr_ap_reg) bank_active[wr_bank_reg] <= 1'b0;
                end
            end
            if (rd_go) begin
                rd_idx_reg  <= rd_idx_reg + 3'h1;
                rd_left_reg <= rd_left_reg - 4'h1;
            end
            case (cmd)
                `SDWIT_CMD_ACTV: begin
                    bank_active[s_bank] <= 1'b1;
                end
                `SDWIT_CMD_WRITE: begin
                    // Write to an idle bank changes no state here, but its edge still loses a running burst word and a read word
                    if (bank_active[s_bank]) begin
                        write_burst  <= wlen != 4'h1;
                        wr_left_reg  <= wlen - 4'h1;
                        wr_start_reg <= s_addr[2:0];
                        wr_idx_reg   <= 3'h1;
                        wr_bank_reg  <= s_bank;
                        wr_ap_reg    <= s_addr[`SDWIT_AP_BIT];
                        rd_left_reg  <= 4'h0;
                        if (wlen == 4'h1 && s_addr[`SDWIT_AP_BIT])
                            bank_active[s_bank] <= 1'b0;
                    end
                end
                `SDWIT_CMD_READ: begin
                    write_burst  <= 1'b0;
                    rd_left_reg  <= burst_len;
                    rd_start_reg <= s_addr[2:0];
                    rd_idx_reg   <= 3'h0;
                    rd_bank_reg  <= s_bank;
                end
                `SDWIT_CMD_DEAC: begin
                    write_burst <= 1'b0;
                    rd_left_reg <= 4'h0;
                    if (s_addr[`SDWIT_AP_BIT]) bank_active <= 2'h0;
                    else bank_active[s_bank] <= 1'b0;
                end
                `SDWIT_CMD_STOP: begin
                    write_burst <= 1'b0;
                    rd_left_reg <= 4'h0;
                end
                `SDWIT_CMD_MRS: begin
                    // Only legal words with both banks idle are taken
                    if (bank_active == 2'h0 && s_addr[8:7] == 2'h0 &&
                        s_addr[6:4] != 3'h0 && s_addr[6:4] < 3'h4 &&
                        s_addr[2:0] < 3'h4) begin
                        bl_reg  <= s_addr[2:0];
                        ilv_reg <= s_addr[`SDWIT_MODE_BT_BIT];
                        rl_reg  <= s_addr[5:4];
                        wb1_reg <= s_addr[`SDWIT_MODE_WB1_BIT];
                    end
                end
                default: begin
                    // Refresh and no-op change no burst state
                end
            endcase
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_pipe_reg <= 3'h0;
            rd_dly1_reg <= {DW{1'b0}};
            rd_dly2_reg <= {DW{1'b0}};
            dq_out      <= {DW{1'b0}};
            dq_oe_n     <= 1'b1;
        end else begin
            rd_pipe_reg <= {rd_pipe_reg[1:0], rd_go && !new_write};
            rd_dly1_reg <= mem_rdata;
            rd_dly2_reg <= rd_dly1_reg;
            // Data must take the same tap as the enable, or words slip
            case (rl_reg)
                2'h1: dq_out <= mem_rdata;
                2'h2: dq_out <= rd_dly1_reg;
                default: dq_out <= rd_dly2_reg;
            endcase
            // Storage read adds one cycle, so latency one taps stage zero
            dq_oe_n     <= !rd_pipe_reg[rl_reg - 2'h1];
        end
    end
endmodule // sdwit_core
`default_nettype wire

/* logic/sdwit_map.vh */
`ifndef SDWIT_MAP_VH
`define SDWIT_MAP_VH
// Command encodings on {ras_n, cas_n, we_n} with chip selected
`define SDWIT_CMD_NOP      3'h7
`define SDWIT_CMD_ACTV     3'h3
`define SDWIT_CMD_READ     3'h5
`define SDWIT_CMD_WRITE    3'h4
`define SDWIT_CMD_DEAC     3'h2
`define SDWIT_CMD_AUTO_REFRESH_COMMAND     3'h1
`define SDWIT_CMD_MRS      3'h0
`define SDWIT_CMD_STOP     3'h6
// Mode word field positions
`define SDWIT_MODE_BL_LSB  0
`define SDWIT_MODE_BT_BIT  3
`define SDWIT_MODE_RL_LSB  4
`define SDWIT_MODE_WB1_BIT 9
// Reset values
`define SDWIT_RL_RESET     2'h3
`define SDWIT_BL_RESET     3'h2
// Auto-deactivate and all-bank address bit, and bank select bit
`define SDWIT_AP_BIT       10
`define SDWIT_BANK_BIT     11
`endif

/* sim/sdram_write_interrupt_init_timing_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdwit_map.vh"
// Bench: shadow memory predicts every word read back
module sdram_write_interrupt_init_timing_tb_top;
    logic        clock, rst, cs_n, ras_n, cas_n, we_n, dq_oe_n, write_burst;
    logic [11:0] addr;
    logic [1:0]  dqm, bank_active;
    logic [15:0] dq_in, dq_out, seed, lat;
    logic [15:0] mem [16];   // Bank 0 shadow
    int          n_errors, comparisons;
    sdwit_core #(.AW(4), .DW(16)) DUT (.clock, .rst, .cs_n, .ras_n,
        .cas_n, .we_n, .addr, .dqm, .dq_in, .dq_out, .dq_oe_n,
        .bank_active, .write_burst);
    sdwit_ctl_model ctl (.clock, .cs_n, .ras_n, .cas_n, .we_n, .addr,
        .dqm, .dq_in);
    // 8 ns clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Serial burst words; mask applies to the last word only
    task automatic wr(input logic [2:0] col, input int n, input logic [1:0] m);
        logic [1:0] mk;
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            mk = (i == n - 1) ? m : 2'h0;
            ctl.cmd(i == 0 ? `SDWIT_CMD_WRITE : `SDWIT_CMD_NOP, {9'h0, col},
                    seed, mk);
            if (!mk[0]) mem[col + i][7:0] = seed[7:0];
            if (!mk[1]) mem[col + i][15:8] = seed[15:8];
        end
    endtask
    // Bounded wait for the first word, then four in a row
    task automatic rd(input logic [2:0] col);
        int k;
        ctl.cmd(`SDWIT_CMD_READ, {9'h0, col}, seed, 2'h0);
        k = 0;
        do begin
            ctl.idle(1);
            k++;
        end while (dq_oe_n !== 1'b0 && k < 12);
        check({15'h0, dq_oe_n}, 16'h0000);
        // Latency plus two sync cycles, the command edge and the storage read
        check(k[15:0], lat + 16'h0004);
        for (int i = 0; i < 4; i++) begin
            check(dq_out, mem[col + i]);
            ctl.idle(1);
        end
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        seed = 16'h0018;
        lat = 16'h0003;
        n_errors = 0;
        comparisons = 0;
        repeat (2) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        ctl.init_seq(25000, 12'h032);
        ctl.act(1'b0);
        wr(3'h0, 4, 2'h0);
        wr(3'h4, 4, 2'h0);
        ctl.idle(2);
        rd(3'h0);
        rd(3'h4);
        // Second write cuts the first
        wr(3'h0, 2, 2'h0);
        wr(3'h4, 4, 2'h0);
        ctl.idle(2);
        rd(3'h0);
        rd(3'h4);
        // Read cuts a write; high byte only on word two
        wr(3'h0, 2, 2'h1);
        rd(3'h0);
        wr(3'h4, 2, 2'h0);
        ctl.stop;
        rd(3'h4);
        check({15'h0, bank_active[0]}, 16'h0001);
        // Last word fully masked ahead of deactivate
        wr(3'h0, 2, 2'h3);
        ctl.deac;
        check({15'h0, bank_active[0]}, 16'h0000);
        ctl.act(1'b0);
        rd(3'h0);
        // Write to the idle bank starts no burst
        ctl.cmd(`SDWIT_CMD_WRITE, 12'h800, seed, 2'h0);
        ctl.idle(4);
        check({14'h0, bank_active}, 16'h0001);
        check({15'h0, write_burst}, 16'h0000);
        // Mode set with a bank open is refused; latency stays three
        ctl.cmd(`SDWIT_CMD_MRS, 12'h012, seed, 2'h0);
        ctl.idle(2);
        rd(3'h0);
        // Close both banks, then program latency two
        ctl.cmd(`SDWIT_CMD_DEAC, 12'h400, seed, 2'h0);
        ctl.idle(5);
        ctl.cmd(`SDWIT_CMD_MRS, 12'h022, seed, 2'h0);
        ctl.idle(12);
        lat = 16'h0002;
        ctl.act(1'b0);
        rd(3'h0);
        // Write with auto-deactivate closes the bank at burst end
        ctl.cmd(`SDWIT_CMD_WRITE, 12'h404, seed, 2'h3);
        ctl.idle(8);
        check({14'h0, bank_active}, 16'h0000);
        wrap_up;
    end
    // Run needs about 25300 cycles
    initial begin
        #400000;
        n_errors++;
        wrap_up;
    end
endmodule // sdram_write_interrupt_init_timing_tb_top
bind sdwit_core sdwit_props props (.clock, .rst, .cs_n, .ras_n, .cas_n,
    .we_n, .addr, .dqm, .dq_in, .dq_out, .dq_oe_n, .bank_active,
    .write_burst);
`default_nettype wire

/* sim/sdwit_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdwit_map.vh"
// Controller side; pins change only after a falling edge
module sdwit_ctl_model (
    // Clock
    input wire logic         clock,
    // Pins toward the core
    output var logic         cs_n,
    output var logic         ras_n,
    output var logic         cas_n,
    output var logic         we_n,
    output var logic [11:0]  addr,
    output var logic [1:0]   dqm,
    output var logic [15:0]  dq_in
);
    localparam int T_RCD = 4;
    localparam int T_RP  = 5;
    localparam int T_RC  = 12;
    // Deselected at time zero
    initial begin
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = `SDWIT_CMD_NOP;
        addr = 12'h000;
        dqm = 2'h0;
        dq_in = 16'h0000;
    end
    // One selected command cycle
    task automatic cmd(input logic [2:0] c, input logic [11:0] a,
                       input logic [15:0] d, input logic [1:0] m);
        @(negedge clock);
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = c;
        addr = a;
        dq_in = d;
        dqm = m;
    endtask
    // Released lines toggle so stale values never look valid
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clock);
            cs_n = 1'b1;
            addr = ~addr;
            dq_in = ~dq_in;
            dqm = 2'h0;
        end
    endtask
    task automatic init_seq(input int pause, input logic [11:0] mode);
        idle(pause);
        // Data is a don't-care here, so it keeps toggling
        cmd(`SDWIT_CMD_DEAC, 12'h400, ~dq_in, 2'h3);
        idle(T_RP);
        repeat (8) begin
            cmd(`SDWIT_CMD_AUTO_REFRESH_COMMAND, 12'h000, ~dq_in, 2'h3);
            idle(T_RC);
        end
        cmd(`SDWIT_CMD_MRS, mode, ~dq_in, 2'h3);
        idle(T_RC);
    endtask
    task automatic act(input logic b);
        cmd(`SDWIT_CMD_ACTV, {b, 11'h000}, ~dq_in, 2'h0);
        idle(T_RCD);
    endtask
    task automatic deac;
        cmd(`SDWIT_CMD_DEAC, 12'h000, ~dq_in, 2'h0);
        idle(T_RP);
    endtask
    task automatic stop;
        cmd(`SDWIT_CMD_STOP, 12'h000, ~dq_in, 2'h0);
        idle(2);
    endtask
endmodule // sdwit_ctl_model
`default_nettype wire

/* sim/sdwit_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdwit_map.vh"
// Checker on the core's pins and visible state
module sdwit_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Command pins
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [11:0] addr,
    input wire logic [1:0]  dqm,
    input wire logic [15:0] dq_in,
    // Core outputs
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe_n,
    input wire logic [1:0]  bank_active,
    input wire logic        write_burst
);
    // Deselect counts as no operation
    wire [2:0] cmd = cs_n ? `SDWIT_CMD_NOP : {ras_n, cas_n, we_n};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Write to live bank 0, then one plain cycle
    sequence wr_open;
        cmd == `SDWIT_CMD_WRITE && !addr[11] && bank_active[0]
        ##1 cmd == `SDWIT_CMD_NOP;
    endsequence
    burst_len_a: assert property (
        wr_open ##1 cmd == `SDWIT_CMD_NOP [*2]
        |-> write_burst [*3] ##1 !write_burst)
        else $error("write burst length wrong");
    stop_keeps_a: assert property (
        wr_open ##1 cmd == `SDWIT_CMD_STOP
        |-> ##3 (!write_burst && bank_active[0]))
        else $error("stop did not end burst");
    deac_cuts_a: assert property (
        wr_open ##1 cmd == `SDWIT_CMD_DEAC && !addr[11]
        |-> ##3 (!write_burst && !bank_active[0]))
        else $error("deactivate did not end burst");
    read_cuts_a: assert property (
        wr_open ##1 cmd == `SDWIT_CMD_READ |-> ##3 !write_burst)
        else $error("read did not end burst");
    write_again_a: assert property (
        wr_open ##1 cmd == `SDWIT_CMD_WRITE ##1 cmd == `SDWIT_CMD_NOP
        |-> ##3 write_burst [*2])
        else $error("new write did not restart burst");
    idle_refuse_a: assert property (
        cmd == `SDWIT_CMD_WRITE && addr[11] && !bank_active[1]
        && !write_burst ##1 cmd == `SDWIT_CMD_NOP [*2] |-> ##1 !write_burst)
        else $error("write to idle bank accepted");
    act_opens_a: assert property (
        cmd == `SDWIT_CMD_ACTV && !addr[11] |-> ##3 bank_active[0])
        else $error("activate not seen");
    read_words_a: assert property (
        cmd == `SDWIT_CMD_READ && !write_burst
        |-> ##[2:10] !dq_oe_n [*4] ##1 dq_oe_n)
        else $error("read burst shape wrong");
endmodule // sdwit_props
`default_nettype wire
